// ==== design/sla_pkg.sv ====
// Purpose: Shared constants and types for the lane arithmetic group
// Assumes: One operation issued at a time by the pipeline
// Notes: Lane formats follow element sizes of 8, 16, 32 and 64 bits
package sla_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SLA_VEC_W = 128;
  localparam int SLA_GPR_W = 64;
  localparam int SLA_WORD_W = 32;
  localparam int SLA_IMM_W = 10;
  localparam int SLA_IMM_BYTE_W = 8;
  localparam int SLA_SHF_W = 2;
  localparam int SLA_FMT_W = 2;

  // ----------------------------------------------------------------
  // Lane formats
  // ----------------------------------------------------------------
  localparam logic [1:0] SLA_FMT_B = 2'h0;
  localparam logic [1:0] SLA_FMT_H = 2'h1;
  localparam logic [1:0] SLA_FMT_WD = 2'h2;
  localparam logic [1:0] SLA_FMT_D = 2'h3;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLA_OP_IMM_BROADCAST = 4'h0,
    SLA_OP_SHIFT_ADD = 4'h1,
    SLA_OP_Q_MUL_ACC = 4'h2,
    SLA_OP_Q_MUL_ACC_RND = 4'h3,
    SLA_OP_INT_MUL_ACC = 4'h4,
    SLA_OP_MAX_MAG = 4'h5,
    SLA_OP_MAX_SIGNED = 4'h6,
    SLA_OP_MAX_UNSIGNED = 4'h7
  } sla_op_t;

  // ----------------------------------------------------------------
  // Result state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLA_ST_IDLE = 2'b01,
    SLA_ST_DONE = 2'b10
  } sla_state_t;

endpackage : sla_pkg

// ==== design/sla_lane.sv ====
// Purpose: One lane of width N for multiply-add and maximum operations
// Assumes: Operands arrive already split into lanes
// Notes: Purely combinational; instantiated per lane and format
`timescale 1ns/1ns
module sla_lane #(
  parameter int N = 16
) (
  // Operation select
  input wire sla_pkg::sla_op_t op_i,
  // Lane operands
  input wire logic [N-1:0] dst_i,
  input wire logic [N-1:0] src_a_i,
  input wire logic [N-1:0] src_b_i,
  // Lane result
  output logic [N-1:0] res_o
);
  import sla_pkg::*;

  // Exact signed product, never saturated
  wire signed [2*N-1:0] prod_s = $signed({{N{src_a_i[N-1]}}, src_a_i}) *
                                 $signed({{N{src_b_i[N-1]}}, src_b_i});
  // Accumulator aligned left by n-1 zero bits
  wire [2*N-1:0] acc_al = {dst_i[N-1], dst_i, {(N-1){1'b0}}};
  wire [2*N-1:0] qsum = acc_al + prod_s;
  wire [2*N-1:0] rnd_one = {{(N+1){1'b0}}, 1'b1, {(N-2){1'b0}}};
  wire [2*N-1:0] qsum_r = qsum + rnd_one;
  wire [2*N-1:0] qsel = (op_i == SLA_OP_Q_MUL_ACC_RND) ? qsum_r : qsum;
  // Upper n+1 bits saturated to n bits
  wire [N:0] top = qsel[2*N-1:N-1];
  wire pos_ovf = !top[N] && top[N-1];
  wire neg_ovf = top[N] && !top[N-1];
  wire [N-1:0] q_res = pos_ovf ? {1'b0, {(N-1){1'b1}}} :
                       neg_ovf ? {1'b1, {(N-1){1'b0}}} : top[N-1:0];
  // Integer multiply-add keeps low half only
  wire [2*N-1:0] iprod = src_a_i * src_b_i;
  wire [N-1:0] int_res = dst_i + iprod[N-1:0];
  // Magnitudes, zero-extended
  wire [N-1:0] neg_a = -src_a_i;
  wire [N-1:0] neg_b = -src_b_i;
  wire [N:0] mag_a = {1'b0, src_a_i[N-1] ? neg_a : src_a_i};
  wire [N:0] mag_b = {1'b0, src_b_i[N-1] ? neg_b : src_b_i};
  wire [N-1:0] max_mag = (mag_a > mag_b) ? src_a_i : src_b_i;
  wire [N-1:0] max_sgn = ($signed(src_a_i) > $signed(src_b_i)) ? src_a_i : src_b_i;
  wire [N-1:0] max_uns = (src_a_i > src_b_i) ? src_a_i : src_b_i;

  // Result select
  always_comb begin
    case (op_i)
      SLA_OP_Q_MUL_ACC, SLA_OP_Q_MUL_ACC_RND: res_o = q_res; // RULE12 RULE13 RULE14 RULE15
      SLA_OP_INT_MUL_ACC: res_o = int_res; // RULE16
      SLA_OP_MAX_MAG: res_o = max_mag; // RULE17 RULE18
      SLA_OP_MAX_SIGNED: res_o = max_sgn; // RULE19
      SLA_OP_MAX_UNSIGNED: res_o = max_uns;
      default: res_o = '0;
    endcase
  end

endmodule : sla_lane

// ==== design/sla_shift_add.sv ====
// Purpose: Scalar shift-add with sign extension of the word sum
// Assumes: Second operand holds a sign-extended word
// Notes: Wraps silently; no overflow signalling exists
`timescale 1ns/1ns
module sla_shift_add (
  // Operands
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_a_i,
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_b_i,
  input wire logic [sla_pkg::SLA_SHF_W-1:0] shift_field_i,
  // Result
  output logic [sla_pkg::SLA_GPR_W-1:0] res_o
);
  import sla_pkg::*;

  // Shift by field plus one, zero filled, then add
  wire [SLA_SHF_W:0] amt = {1'b0, shift_field_i} + {{SLA_SHF_W{1'b0}}, 1'b1};
  wire [SLA_WORD_W-1:0] shifted = scalar_src_a_i[SLA_WORD_W-1:0] << amt; // RULE5
  wire [SLA_WORD_W-1:0] sum = shifted + scalar_src_b_i[SLA_WORD_W-1:0]; // RULE5 RULE7 RULE9

  // Sign extension of the low word
  assign res_o = {{(SLA_GPR_W-SLA_WORD_W){sum[SLA_WORD_W-1]}}, sum}; // RULE6

endmodule : sla_shift_add

// ==== design/sla_top.sv ====
// Purpose: Lane arithmetic group datapath: broadcast, shift-add, multiply-add, maximum
// Assumes: Pipeline holds operands stable during the issue cycle
// Notes: One cycle latency; results registered
// Overview of operation
// RULE1: Split vector into lanes by format
// RULE2: Broadcast immediate into every lane
// RULE3: Byte broadcast uses immediate bits seven..zero
// RULE4: Wider broadcast sign-extends immediate bit nine
// RULE5: Shift low word, zero fill, add
// RULE6: Sign-extend low word of sum
// RULE7: Shift-add never raises overflow
// RULE8: Shift-add needs present bit, else reserved
// RULE9: Software supplies sign-extended second operand
// RULE10: Exact double-width product, never saturated
// RULE11: Double-width math, accumulator aligned left
// RULE12: Saturate upper n+1 bits to n
// RULE13: Saturation picks max positive or min negative
// RULE14: Truncate only after saturation
// RULE15: Rounding adds one at discarded msb
// RULE16: Integer multiply-add keeps low bits
// RULE17: Magnitude max picks first only when larger
// RULE18: Most negative has largest magnitude
// RULE19: Signed max picks first when greater
// RULE20: No data-dependent exceptions in vector ops
// RULE21: One op in, result and flag out
`timescale 1ns/1ns
module sla_top #(
  parameter int VEC_W = sla_pkg::SLA_VEC_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Issue
  input wire logic issue_valid_i,
  input wire sla_pkg::sla_op_t op_i,
  input wire logic [sla_pkg::SLA_FMT_W-1:0] lane_format_i,
  input wire logic simd_present_bit_i,
  // Vector operands
  input wire logic [VEC_W-1:0] vec_dest_i,
  input wire logic [VEC_W-1:0] vec_src_a_i,
  input wire logic [VEC_W-1:0] vec_src_b_i,
  // Scalar operands
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_a_i,
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_b_i,
  input wire logic [sla_pkg::SLA_SHF_W-1:0] shift_field_i,
  input wire logic [sla_pkg::SLA_IMM_W-1:0] signed_imm_ten_i,
  // Results
  output logic result_valid_o,
  output logic [VEC_W-1:0] vec_result_o,
  output logic [sla_pkg::SLA_GPR_W-1:0] scalar_result_o,
  output logic reserved_exc_o
);
  import sla_pkg::*;

  // ----------------------------------------------------------------
  // Lane arrays per format
  // ----------------------------------------------------------------
  wire [VEC_W-1:0] res_b;
  wire [VEC_W-1:0] res_h;
  wire [VEC_W-1:0] res_w;
  wire [VEC_W-1:0] res_d;

  // Byte lanes
  for (genvar i = 0; i < VEC_W / 8; i++) begin : g_b
    sla_lane #(.N(8)) u_lane (
      .op_i(op_i),
      .dst_i(vec_dest_i[8*i +: 8]),
      .src_a_i(vec_src_a_i[8*i +: 8]),
      .src_b_i(vec_src_b_i[8*i +: 8]),
      .res_o(res_b[8*i +: 8]) // RULE1
    );
  end

  // Halfword lanes
  for (genvar i = 0; i < VEC_W / 16; i++) begin : g_h
    sla_lane #(.N(16)) u_lane (
      .op_i(op_i),
      .dst_i(vec_dest_i[16*i +: 16]),
      .src_a_i(vec_src_a_i[16*i +: 16]),
      .src_b_i(vec_src_b_i[16*i +: 16]),
      .res_o(res_h[16*i +: 16]) // RULE1
    );
  end

  // Word lanes
  for (genvar i = 0; i < VEC_W / 32; i++) begin : g_w
    sla_lane #(.N(32)) u_lane (
      .op_i(op_i),
      .dst_i(vec_dest_i[32*i +: 32]),
      .src_a_i(vec_src_a_i[32*i +: 32]),
      .src_b_i(vec_src_b_i[32*i +: 32]),
      .res_o(res_w[32*i +: 32]) // RULE1 RULE10 RULE11
    );
  end

  // Doubleword lanes
  for (genvar i = 0; i < VEC_W / 64; i++) begin : g_d
    sla_lane #(.N(64)) u_lane (
      .op_i(op_i),
      .dst_i(vec_dest_i[64*i +: 64]),
      .src_a_i(vec_src_a_i[64*i +: 64]),
      .src_b_i(vec_src_b_i[64*i +: 64]),
      .res_o(res_d[64*i +: 64]) // RULE1
    );
  end

  // ----------------------------------------------------------------
  // Immediate broadcast
  // ----------------------------------------------------------------
  wire imm_sign = signed_imm_ten_i[SLA_IMM_W-1];
  wire [7:0] imm_b = signed_imm_ten_i[SLA_IMM_BYTE_W-1:0]; // RULE3
  wire [15:0] imm_h = {{(16-SLA_IMM_W){imm_sign}}, signed_imm_ten_i}; // RULE4
  wire [31:0] imm_w = {{(32-SLA_IMM_W){imm_sign}}, signed_imm_ten_i}; // RULE4
  wire [63:0] imm_d = {{(64-SLA_IMM_W){imm_sign}}, signed_imm_ten_i}; // RULE4
  wire [VEC_W-1:0] bc_b = {(VEC_W/8){imm_b}}; // RULE2
  wire [VEC_W-1:0] bc_h = {(VEC_W/16){imm_h}}; // RULE2
  wire [VEC_W-1:0] bc_w = {(VEC_W/32){imm_w}}; // RULE2
  wire [VEC_W-1:0] bc_d = {(VEC_W/64){imm_d}}; // RULE2

  // Format selection
  wire [VEC_W-1:0] lane_res = (lane_format_i == SLA_FMT_B) ? res_b :
                              (lane_format_i == SLA_FMT_H) ? res_h :
                              (lane_format_i == SLA_FMT_WD) ? res_w : res_d;
  wire [VEC_W-1:0] bc_res = (lane_format_i == SLA_FMT_B) ? bc_b :
                            (lane_format_i == SLA_FMT_H) ? bc_h :
                            (lane_format_i == SLA_FMT_WD) ? bc_w : bc_d;

  // ----------------------------------------------------------------
  // Scalar shift-add
  // ----------------------------------------------------------------
  wire [SLA_GPR_W-1:0] sa_res;

  sla_shift_add u_shift_add (
    .scalar_src_a_i(scalar_src_a_i),
    .scalar_src_b_i(scalar_src_b_i),
    .shift_field_i(shift_field_i),
    .res_o(sa_res)
  );

  // ----------------------------------------------------------------
  // Result and exception decode
  // ----------------------------------------------------------------
  wire is_shift_add = (op_i == SLA_OP_SHIFT_ADD);
  wire exc_next = is_shift_add && !simd_present_bit_i; // RULE8 RULE20
  wire [VEC_W-1:0] next_vec = (op_i == SLA_OP_IMM_BROADCAST) ? bc_res :
                              is_shift_add ? '0 : lane_res;
  wire [SLA_GPR_W-1:0] next_scalar = (is_shift_add && simd_present_bit_i) ? sa_res : '0;

  // ----------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------
  sla_state_t state;
  sla_state_t next_state;

  // Done for one cycle after each issue
  always_comb begin
    case (state)
      SLA_ST_IDLE: next_state = issue_valid_i ? SLA_ST_DONE : SLA_ST_IDLE;
      SLA_ST_DONE: next_state = issue_valid_i ? SLA_ST_DONE : SLA_ST_IDLE;
      default: next_state = SLA_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= SLA_ST_IDLE;
    end else begin
      state <= next_state; // RULE21
    end
  end

  // Result registers, loaded on issue
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      vec_result_o <= '0;
      scalar_result_o <= '0;
      reserved_exc_o <= 1'b0;
    end else if (issue_valid_i) begin
      vec_result_o <= next_vec;
      scalar_result_o <= next_scalar;
      reserved_exc_o <= exc_next; // RULE8
    end
  end

  assign result_valid_o = (state == SLA_ST_DONE); // RULE21

endmodule : sla_top

// ==== testbench/sla_props.sv ====
// Purpose: Port assertions for the lane arithmetic group
// Assumes: One clock, synchronous reset
// Notes: Bound to sla_top below
`timescale 1ns/1ns
module sla_props import sla_pkg::*; #(
  parameter int VEC_W = SLA_VEC_W
) (
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire sla_pkg::sla_op_t op_i,
  input wire logic [1:0] lane_format_i,
  input wire logic simd_present_bit_i,
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_a_i,
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_src_b_i,
  input wire logic [1:0] shift_field_i,
  input wire logic [9:0] signed_imm_ten_i,
  input wire logic result_valid_o,
  input wire logic [VEC_W-1:0] vec_result_o,
  input wire logic [sla_pkg::SLA_GPR_W-1:0] scalar_result_o,
  input wire logic reserved_exc_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Reference shift-add word sum and issue decodes
  wire logic [31:0] sa_sum = (scalar_src_a_i[31:0] << ({30'h0, shift_field_i} + 32'h1))
    + scalar_src_b_i[31:0];
  wire logic is_sa = issue_valid_i && op_i == SLA_OP_SHIFT_ADD;
  wire logic is_bc = issue_valid_i && op_i == SLA_OP_IMM_BROADCAST;
  lat_valid_a: assert property (issue_valid_i |=> result_valid_o) else $error("no result");
  idle_valid_a: assert property (!issue_valid_i |=> !result_valid_o) else $error("stray valid");
  hold_res_a: assert property (!issue_valid_i |=> $stable(vec_result_o)) else $error("unheld");
  exc_set_a: assert property (is_sa && !simd_present_bit_i |=> reserved_exc_o
    && scalar_result_o == '0) else $error("missing exception");
  sa_value_a: assert property (is_sa && simd_present_bit_i |=> !reserved_exc_o
    && scalar_result_o == {{32{$past(sa_sum[31])}}, $past(sa_sum)}) else $error("bad sum");
  vec_noexc_a: assert property (issue_valid_i && op_i != SLA_OP_SHIFT_ADD |=>
    !reserved_exc_o) else $error("vector exception");
  bc_byte_a: assert property (is_bc && lane_format_i == SLA_FMT_B |=>
    vec_result_o == {(VEC_W/8){$past(signed_imm_ten_i[7:0])}}) else $error("bad byte fill");
  bc_word_a: assert property (is_bc && lane_format_i == 2'h2 |=>
    vec_result_o == {(VEC_W/32){{22{$past(signed_imm_ten_i[9])}}, $past(signed_imm_ten_i)}})
    else $error("bad word fill");
endmodule : sla_props
bind sla_top sla_props #(.VEC_W(VEC_W)) u_props (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .issue_valid_i(issue_valid_i), .op_i(op_i), .lane_format_i(lane_format_i),
  .simd_present_bit_i(simd_present_bit_i), .scalar_src_a_i(scalar_src_a_i),
  .scalar_src_b_i(scalar_src_b_i), .shift_field_i(shift_field_i),
  .signed_imm_ten_i(signed_imm_ten_i), .result_valid_o(result_valid_o),
  .vec_result_o(vec_result_o), .scalar_result_o(scalar_result_o),
  .reserved_exc_o(reserved_exc_o));

// ==== testbench/sla_pipe_sink.sv ====
// Purpose: Pipeline side that retires results
// Assumes: Results valid for one cycle each
// Notes: Counts retirements and exceptions
`timescale 1ns/1ns
module sla_pipe_sink (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Results
  input wire logic result_valid_i,
  input wire logic reserved_exc_i,
  // Tallies
  output logic [15:0] retired_o,
  output logic [15:0] exc_seen_o
);
  // Count results as they retire
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      retired_o <= 16'h0;
      exc_seen_o <= 16'h0;
    end else if (result_valid_i) begin
      retired_o <= retired_o + 16'h1;
      exc_seen_o <= exc_seen_o + {15'h0, reserved_exc_i};
    end
  end
endmodule : sla_pipe_sink

// ==== testbench/simd_lane_arith_group_test.sv ====
// Purpose: Directed bench for the lane arithmetic group
// Assumes: Inputs change on the falling edge
// Notes: One result per issue, one cycle later
`timescale 1ns/1ns
module simd_lane_arith_group_test;
  import sla_pkg::*;
  logic ref_clk_i, srst_i, iv, pres, rv, exc;
  sla_op_t op;
  logic [1:0] fmt, sh;
  logic [127:0] vd, va, vb, vr;
  logic [63:0] sa, sb, sr;
  logic [9:0] imm;
  logic [15:0] retired, exc_seen;
  int bad_count, checks_done, cycles, issued;
  sla_top uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .issue_valid_i(iv), .op_i(op),
    .lane_format_i(fmt), .simd_present_bit_i(pres), .vec_dest_i(vd), .vec_src_a_i(va),
    .vec_src_b_i(vb), .scalar_src_a_i(sa), .scalar_src_b_i(sb), .shift_field_i(sh),
    .signed_imm_ten_i(imm), .result_valid_o(rv), .vec_result_o(vr),
    .scalar_result_o(sr), .reserved_exc_o(exc));
  sla_pipe_sink sink (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .result_valid_i(rv),
    .reserved_exc_i(exc), .retired_o(retired), .exc_seen_o(exc_seen));
  // Clock and hang guard
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Issue one op, then compare vector result
  task automatic run(input sla_op_t o, input logic [1:0] f, input logic [127:0] d, a, b, ex);
    @(negedge ref_clk_i);
    op = o;
    fmt = f;
    vd = d;
    va = a;
    vb = b;
    iv = 1'b1;
    issued++;
    @(negedge ref_clk_i);
    iv = 1'b0;
    check("valid", {127'h0, rv}, 128'h1);
    check("vector", vr, ex);
  endtask : run
  task automatic t_bcast();
    imm = 10'h2A5;
    run(SLA_OP_IMM_BROADCAST, 2'h0, '0, '0, '0, {16{8'hA5}});
    run(SLA_OP_IMM_BROADCAST, 2'h1, '0, '0, '0, {8{16'hFEA5}});
    run(SLA_OP_IMM_BROADCAST, 2'h2, '0, '0, '0, {4{32'hFFFF_FEA5}});
    run(SLA_OP_IMM_BROADCAST, 2'h3, '0, '0, '0, {2{64'hFFFF_FFFF_FFFF_FEA5}});
  endtask : t_bcast
  task automatic t_shift_add();
    pres = 1'b1;
    sa = 64'hFFFF_FFFF_C000_0001;
    sb = 64'hFFFF_FFFF_8000_0000;
    sh = 2'h3;
    run(SLA_OP_SHIFT_ADD, 2'h2, '0, '0, '0, '0);
    check("sum", {64'h0, sr}, {64'h0, 64'hFFFF_FFFF_8000_0010});
    sa = 64'h0000_0000_4000_0000;
    sb = 64'h0000_0000_7FFF_FFFF;
    sh = 2'h0;
    run(SLA_OP_SHIFT_ADD, 2'h2, '0, '0, '0, '0);
    check("wrap", {64'h0, sr}, {64'h0, 64'hFFFF_FFFF_FFFF_FFFF});
    check("no overflow", {127'h0, exc}, 128'h0);
    pres = 1'b0;
    run(SLA_OP_SHIFT_ADD, 2'h2, '0, '0, '0, '0);
    check("reserved", {63'h0, exc, sr}, {64'h1, 64'h0});
  endtask : t_shift_add
  task automatic t_mul();
    run(SLA_OP_Q_MUL_ACC, 2'h1, {4{32'h8000_0000}}, {8{16'h8000}}, {4{32'h7FFF_8000}},
      {4{32'h8000_7FFF}});
    run(SLA_OP_Q_MUL_ACC, 2'h2, '0, {4{32'h8000_0000}}, {4{32'h8000_0000}},
      {4{32'h7FFF_FFFF}});
    run(SLA_OP_Q_MUL_ACC, 2'h2, {4{32'h8000_0000}}, {4{32'h8000_0000}}, {4{32'h8000_0000}},
      '0);
    run(SLA_OP_Q_MUL_ACC, 2'h1, '0, {8{16'h4000}}, {8{16'h0001}}, '0);
    run(SLA_OP_Q_MUL_ACC_RND, 2'h1, '0, {8{16'h4000}}, {8{16'h0001}}, {8{16'h0001}});
    run(SLA_OP_INT_MUL_ACC, 2'h0, {16{8'h05}}, {16{8'h10}}, {16{8'h11}}, {16{8'h15}});
    run(SLA_OP_INT_MUL_ACC, 2'h3, {2{64'h1}}, '1, {2{64'h2}}, '1);
  endtask : t_mul
  task automatic t_max();
    run(SLA_OP_MAX_MAG, 2'h1, '0, {4{32'h8000_FFFF}}, {4{32'h7FFF_0001}},
      {4{32'h8000_0001}});
    vb = {2{64'h7FFF_FFFF_0000_0003}};
    run(SLA_OP_MAX_SIGNED, 2'h2, '0, {2{64'h8000_0000_0000_0005}}, vb,
      {2{64'h7FFF_FFFF_0000_0005}});
    run(SLA_OP_MAX_UNSIGNED, 2'h2, '0, {2{64'h8000_0000_0000_0005}}, vb,
      {2{64'h8000_0000_0000_0005}});
    check("vector exception", {127'h0, exc}, 128'h0);
  endtask : t_max
  // Main sequence
  initial begin
    {srst_i, iv, pres, fmt, sh, vd, va, vb, sa, sb, imm} = '0;
    srst_i = 1'b1;
    op = SLA_OP_IMM_BROADCAST;
    repeat (6) @(negedge ref_clk_i);
    srst_i = 1'b0;
    check("reset", {rv, exc, sr, vr[61:0]}, '0);
    t_bcast();
    t_shift_add();
    t_mul();
    t_max();
    repeat (2) @(negedge ref_clk_i);
    check("retired", {exc_seen, retired}, {16'h1, 16'(issued)});
    tally_and_finish();
  end
endmodule : simd_lane_arith_group_test
